// >>> pkg/ctw_pkg.sv
package ctw_pkg;

  // APB bus widths.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // Printed register offsets are kept as indices; the byte address is four times the index.
  localparam logic [ADDR_W-1:0] IDX_CTRL = 16'h0008;
  localparam logic [ADDR_W-1:0] IDX_COUNT = 16'h0009;
  localparam logic [ADDR_W-1:0] IDX_WDOG = 16'h3FF0;

  // Control and status field positions.
  localparam int B_OVF_FLAG = 7;
  localparam int B_PER_FLAG = 6;
  localparam int B_OVF_EN = 5;
  localparam int B_PER_EN = 4;
  localparam int B_OVF_CLR = 3;
  localparam int B_PER_CLR = 2;
  localparam int B_RATE_HI = 1;
  localparam int B_RATE_LO = 0;
  localparam int B_WDOG_SVC = 0;

  // Counter chain layout: prescaler, ripple counter, one stage, four periodic stages.
  localparam int CHAIN_W = 15;
  localparam int CNT_LSB = 2;
  localparam int CNT_MSB = 9;
  localparam int TAP_BASE = 10;
  localparam int NUM_TAPS = 4;
  localparam int WDOG_W = 3;

  // Reset values and timing counts.
  localparam logic [1:0] RATE_RST = 2'h3;
  localparam logic [CHAIN_W-1:0] POR_LAST = 15'h0FDF;
  localparam logic [WDOG_W-1:0] WDOG_LAST = 3'h7;
  localparam int RST_PIN_CYC = 3;
  localparam logic [1:0] RST_PIN_LOAD = 2'(RST_PIN_CYC);

  // APB request as seen by the slave.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } ctw_apb_req_s;

  // APB answer from the slave.
  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } ctw_apb_rsp_s;

  // Byte address of a register from its index.
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [ADDR_W-1:0] idx);
    reg_addr = ADDR_W'({idx, 2'b00});
  endfunction

endpackage

// >>> verif/ctw_pin_model.sv
`timescale 1ns/10ps
module ctw_pin_model (
  // Driver of the open-drain reset pin.
  input wire logic pin_o,
  input wire logic pin_oe,
  // External reset switch, high while it pulls the pin down.
  input wire logic ext_low,
  // Resolved pin level.
  output logic pin
);
  // The pin has a pull-up, so it rests high unless someone pulls it down.
  assign pin = (pin_oe ? pin_o : 1'b1) & ~ext_low;
endmodule

// >>> verif/tb.sv
`timescale 1ns/10ps
module tb;
  import ctw_pkg::*;
  localparam logic [15:0] A_CTRL = 16'h0020;
  localparam logic [15:0] A_CNT = 16'h0024;
  localparam logic [15:0] A_WDG = 16'hFFC0;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic wdog_enable, stop_disabled, stop_exec, ext_low, pin, pin_o, pin_oe, timer_irq, cpu_reset;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd, c0;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0, t1, tw, n;
  ctw_core_timer ctw_core_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdog_enable(wdog_enable),
    .stop_disabled(stop_disabled), .stop_exec(stop_exec), .reset_pin_i(pin),
    .reset_pin_o(pin_o), .reset_pin_oe(pin_oe), .timer_irq(timer_irq), .cpu_reset(cpu_reset));
  ctw_pin_model ctw_pin_model_i (.pin_o(pin_o), .pin_oe(pin_oe), .ext_low(ext_low), .pin(pin));
  // Clock of 25 ns and a free cycle count for timing checks.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; an idle edge follows so the next call never reassigns psel at once.
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return timer_irq;
      1: return pin_oe;
      2: return cpu_reset;
      default: return ~cpu_reset;
    endcase
  endfunction
  // Bounded wait for a design output; a wait that runs out counts as a mismatch.
  task automatic wait_on(input int s, input int lim);
    int k;
    k = 0;
    while (sig(s) !== 1'b1 && k < lim) begin
      k++;
      @(posedge pclk);
    end
    chk("wait done", 1, k < lim);
    tw = cyc;
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog against a hang, sized a little above the full run.
  initial begin
    #2400000;
    err_total++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, stop_disabled, stop_exec, ext_low, wdog_enable} = 8'h00;
    paddr = 16'h0000;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t0 = cyc;
    wait_on(3, 5000);
    chk("por length", 1, (tw - t0 >= 4064) && (tw - t0 <= 4072));
    apb(0, A_CTRL, 0);
    chk("ctrl reset", 32'h03, rd);
    apb(0, A_CNT, 0);
    c0 = rd;
    repeat (37) @(posedge pclk);
    apb(0, A_CNT, 0);
    chk("count step", (c0 + 10) & 32'hFF, rd);
    repeat (1100) @(posedge pclk);
    apb(1, A_CTRL, 32'h03);
    apb(0, A_CTRL, 0);
    chk("ovf kept", 32'h83, rd);
    apb(1, A_CTRL, 32'h4B);
    apb(0, A_CTRL, 0);
    chk("ovf cleared", 32'h03, rd);
    apb(1, A_CTRL, 32'h23);
    wait_on(0, 1100);
    apb(1, A_CTRL, 32'h0B);
    $display("test flags done");
    for (int r = 0; r < 4; r++) begin
      apb(1, A_WDG, 0);
      apb(1, A_CTRL, 32'h14 | r);
      wait_on(0, 1 << (12 + r));
      t1 = tw;
      apb(1, A_CTRL, 32'h14 | r);
      apb(0, A_CTRL, 0);
      chk("per cleared", 32'h10 | r, rd & 32'h7F);
      wait_on(0, 1 << (12 + r));
      chk("per period", 1 << (11 + r), tw - t1);
    end
    $display("test rates done");
    wdog_enable <= 1'b1;
    apb(1, A_CTRL, 32'h04);
    apb(1, A_WDG, 0);
    t0 = cyc;
    wait_on(1, 8 * 2048 + 20);
    chk("wdog time", 1, (tw - t0 > 7 * 2048) && (tw - t0 <= 8 * 2048 + 8));
    chk("wdog reset", 1, cpu_reset);
    n = 0;
    while (pin_oe === 1'b1 && n < 10) begin
      n++;
      @(posedge pclk);
    end
    chk("pin pulse", 3, n);
    wait_on(3, 50);
    apb(0, A_CTRL, 0);
    chk("ctrl after wdog", 32'h03, rd);
    wdog_enable <= 1'b0;
    $display("test watchdog done");
    stop_disabled <= 1'b1;
    stop_exec <= 1'b1;
    @(posedge pclk);
    stop_exec <= 1'b0;
    wait_on(2, 5);
    wait_on(3, 50);
    stop_disabled <= 1'b0;
    ext_low <= 1'b1;
    wait_on(2, 5);
    apb(1, A_CTRL, 32'h30);
    ext_low <= 1'b0;
    wait_on(3, 20);
    apb(0, A_CNT, 0);
    chk("count cleared", 0, rd);
    apb(0, A_CTRL, 0);
    chk("ctrl after pin", 32'h03, rd);
    apb(0, 16'h0028, 0);
    chk("unmapped err", 1, er);
    apb(0, A_WDG, 0);
    chk("wdog reads", 0, rd);
    $display("test resets done");
    end_of_test();
  end
endmodule

// >>> verilog/ctw_core_timer.sv
// Function
// - Bus clock divided by four clocks an 8-bit ripple counter heading the chain.
// - Count register at index 09 reads the live ripple count, read-only, undisturbed.
// - Overflow flag sets when the ripple counter rolls from FF to 00.
// - One further stage gives bus clock over 2048 feeding the periodic divider.
// - Rate select 00..11 picks periods of 2^11, 2^12, 2^13, 2^14 clocks.
// - Periodic flag sets on each selected tap event; direct writes ignored.
// - Writing 1 to overflow clear bit clears overflow flag; bit reads zero.
// - Writing 1 to periodic clear bit clears periodic flag; bit reads zero.
// - Interrupt request while overflow enable and overflow flag are both set.
// - Interrupt request while periodic enable and periodic flag are both set.
// - Reset clears both flags and enables and sets rate select to 11.
// - Selected tap divided by eight forms the watchdog; timeout forces internal reset.
// - Watchdog timeout also pulls the reset pin low for at least three clocks.
// - Any chip reset, including the reset pin, clears the whole counter chain.
// - Watchdog stays on in wait; disabled stop instruction causes internal reset.
// - Power-up counts 4064 cycles, then releases reset and clears the chain again.
// - Chain and watchdog keep running in wait; timer interrupt wakes the CPU.
`timescale 1ns/10ps
module ctw_core_timer (
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ctw_pkg::ADDR_W-1:0] paddr,
  input wire logic [ctw_pkg::DATA_W-1:0] pwdata,
  output logic [ctw_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration and CPU status.
  input wire logic wdog_enable,
  input wire logic stop_disabled,
  input wire logic stop_exec,
  // Open-drain reset pin.
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  // Towards the CPU core.
  output logic timer_irq,
  output logic cpu_reset
);
  import ctw_pkg::*;

  // Whole state of the block.
  typedef struct packed {
    logic [CHAIN_W-1:0] chain;
    logic [WDOG_W-1:0] wdog_div;
    logic por;
    logic ovf_flag;
    logic per_flag;
    logic ovf_en;
    logic per_en;
    logic [1:0] rate;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [1:0] rst_cnt;
    logic int_rst;
    logic pin_oe;
    logic cpu_rst;
    logic pin_s1;
    logic pin_s2;
    logic wde_s1;
    logic wde_s2;
  } ctw_state_s;

  ctw_state_s s_r;
  ctw_state_s s_nxt;
  ctw_apb_req_s req;

  // Per-tap events: chain bits up to the tap are all ones, so the tap toggles next cycle.
  logic ovf_evt;
  logic [NUM_TAPS-1:0] tap_evt;
  logic per_evt;
  logic hold;
  logic chip_rst;
  logic setup;
  logic access;
  logic svc_wr;
  logic ctrl_wr;
  logic wdog_to;
  logic stop_rst;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // The ripple counter overflows when the prescaler and all eight counter bits are ones.
  assign ovf_evt = &s_r.chain[CNT_MSB:0];

  // One tap per periodic stage; a generate keeps the four comparisons uniform.
  genvar g;
  generate
    for (g = 0; g < NUM_TAPS; g++) begin : g_tap
      assign tap_evt[g] = &s_r.chain[TAP_BASE+g:0];
    end
  endgenerate

  // The selected tap drives both the periodic flag and the watchdog divider.
  assign per_evt = tap_evt[s_r.rate];

  // Reset pin low or an internal reset clears the chain; power-up reset lets it run.
  assign hold = s_r.int_rst | ~s_r.pin_s2;
  assign chip_rst = hold | s_r.por;

  // Bus phases; pready is high in every access phase, so an access ends at its first edge.
  assign setup = req.psel & ~req.penable;
  assign access = req.psel & req.penable & s_r.pready;
  assign ctrl_wr = access & req.pwrite & (req.paddr == reg_addr(IDX_CTRL));
  assign svc_wr = access & req.pwrite & (req.paddr == reg_addr(IDX_WDOG))
                  & ~req.pwdata[B_WDOG_SVC];

  // A watchdog timeout needs the option enabled and the eighth selected tap event.
  assign wdog_to = s_r.wde_s2 & ~chip_rst & per_evt & (s_r.wdog_div == WDOG_LAST) & ~svc_wr;
  // The stop instruction is illegal when the option disables it, and resets the part.
  assign stop_rst = stop_exec & stop_disabled & ~chip_rst;

  // Next-state logic for the whole block.
  always_comb begin
    s_nxt = s_r;
    // Two-flop synchronisers for the pin and the option input.
    s_nxt.pin_s1 = reset_pin_i;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.wde_s1 = wdog_enable;
    s_nxt.wde_s2 = s_r.wde_s1;

    // The chain runs every bus clock, also while the CPU waits; only resets stop it.
    if (hold) begin
      s_nxt.chain = '0;
      s_nxt.wdog_div = '0;
    end else if (s_r.por && s_r.chain == POR_LAST) begin
      s_nxt.por = 1'b0;
      s_nxt.chain = '0;
      s_nxt.wdog_div = '0;
    end else begin
      s_nxt.chain = s_r.chain + 1'b1;
      if (svc_wr) begin
        s_nxt.wdog_div = '0;
      end else if (per_evt && !s_r.por) begin
        s_nxt.wdog_div = s_r.wdog_div + 1'b1;
      end
    end

    // Control and status: reset values while any chip reset is active.
    if (chip_rst) begin
      s_nxt.ovf_flag = 1'b0;
      s_nxt.per_flag = 1'b0;
      s_nxt.ovf_en = 1'b0;
      s_nxt.per_en = 1'b0;
      s_nxt.rate = RATE_RST;
    end else begin
      if (ctrl_wr) begin
        s_nxt.ovf_en = req.pwdata[B_OVF_EN];
        s_nxt.per_en = req.pwdata[B_PER_EN];
        s_nxt.rate = req.pwdata[B_RATE_HI:B_RATE_LO];
        if (req.pwdata[B_OVF_CLR]) begin
          s_nxt.ovf_flag = 1'b0;
        end
        if (req.pwdata[B_PER_CLR]) begin
          s_nxt.per_flag = 1'b0;
        end
      end
      // Setting comes after clearing so that a coincident event is never lost.
      if (ovf_evt) begin
        s_nxt.ovf_flag = 1'b1;
      end
      if (per_evt) begin
        s_nxt.per_flag = 1'b1;
      end
    end

    // The request is a level; it stays up in wait mode and so wakes the CPU.
    s_nxt.irq = ~chip_rst & ((s_nxt.ovf_en & s_nxt.ovf_flag)
                | (s_nxt.per_en & s_nxt.per_flag));

    // Internal reset: pin driven low for the set count; the synced pin then extends it.
    if (wdog_to || stop_rst) begin
      s_nxt.rst_cnt = RST_PIN_LOAD;
    end else if (s_r.rst_cnt != 2'h0) begin
      s_nxt.rst_cnt = s_r.rst_cnt - 1'b1;
    end
    s_nxt.pin_oe = (s_nxt.rst_cnt != 2'h0);
    s_nxt.int_rst = (s_nxt.rst_cnt != 2'h0);
    s_nxt.cpu_rst = s_nxt.por | s_nxt.int_rst | ~s_r.pin_s2;

    // APB: read data is captured in the setup phase and shown through the access phase.
    s_nxt.pready = setup;
    if (setup) begin
      s_nxt.prdata = '0;
      s_nxt.pslverr = 1'b0;
      if (req.paddr == reg_addr(IDX_CTRL)) begin
        s_nxt.prdata[B_OVF_FLAG] = s_r.ovf_flag;
        s_nxt.prdata[B_PER_FLAG] = s_r.per_flag;
        s_nxt.prdata[B_OVF_EN] = s_r.ovf_en;
        s_nxt.prdata[B_PER_EN] = s_r.per_en;
        s_nxt.prdata[B_RATE_HI:B_RATE_LO] = s_r.rate;
      end else if (req.paddr == reg_addr(IDX_COUNT)) begin
        s_nxt.prdata[7:0] = s_r.chain[CNT_MSB:CNT_LSB];
      end else if (req.paddr == reg_addr(IDX_WDOG)) begin
        s_nxt.prdata = '0;
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end else if (!req.psel) begin
      s_nxt.pslverr = 1'b0;
    end
  end

  // State register; power-up starts the chain from zero with the power-on phase active.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.por <= 1'b1;
      s_r.rate <= RATE_RST;
      s_r.pin_s1 <= 1'b1;
      s_r.pin_s2 <= 1'b1;
      s_r.cpu_rst <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register; the pin only ever drives low.
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign timer_irq = s_r.irq;
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe = s_r.pin_oe;
  assign cpu_reset = s_r.cpu_rst;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chain_count_a: assert property (
    !chip_rst |=> s_r.chain == $past(s_r.chain) + 1'b1)
    else $error("chain did not advance by one");

  count_read_a: assert property (
    setup && req.paddr == reg_addr(IDX_COUNT)
    |=> s_r.prdata[7:0] == $past(s_r.chain[CNT_MSB:CNT_LSB]) && s_r.pready)
    else $error("count read returned wrong value");

  ovf_set_a: assert property (
    !chip_rst && ovf_evt |=> s_r.ovf_flag && s_r.chain[CNT_MSB:0] == '0)
    else $error("overflow flag not set on rollover");

  per_set_a: assert property (
    !chip_rst && tap_evt[s_r.rate] |=> s_r.per_flag)
    else $error("periodic flag not set on tap event");

  ovf_clear_a: assert property (
    ctrl_wr && req.pwdata[B_OVF_CLR] && !ovf_evt && !chip_rst |=> !s_r.ovf_flag)
    else $error("overflow flag not cleared");

  per_clear_a: assert property (
    ctrl_wr && req.pwdata[B_PER_CLR] && !per_evt && !chip_rst |=> !s_r.per_flag)
    else $error("periodic flag not cleared");

  irq_level_a: assert property (
    s_r.ovf_en && s_r.ovf_flag && !chip_rst && !ctrl_wr |=> s_r.irq)
    else $error("interrupt request missing");

  reset_vals_a: assert property (
    chip_rst |=> s_r.rate == RATE_RST && !s_r.ovf_en && !s_r.per_en && !s_r.irq)
    else $error("reset values wrong");

  service_clr_a: assert property (
    svc_wr && !hold |=> s_r.wdog_div == '0)
    else $error("watchdog service did not clear");

  pin_low_a: assert property (
    $rose(s_r.pin_oe) |-> s_r.pin_oe [*3] ##1 !s_r.pin_oe)
    else $error("reset pin pulse length wrong");

  pin_chain_a: assert property (
    !s_r.pin_s2 |=> s_r.chain == '0 && s_r.cpu_rst)
    else $error("chain not cleared by reset pin");

  por_end_a: assert property (
    s_r.por && !hold && s_r.chain == POR_LAST |=> !s_r.por && s_r.chain == '0)
    else $error("power-on release wrong");

  wdog_off_a: assert property (
    !s_r.wde_s2 && !stop_exec |=> !$rose(s_r.pin_oe))
    else $error("watchdog reset while disabled");

  per_irq_a: assert property (
    s_r.per_en && s_r.per_flag && !chip_rst && !ctrl_wr |=> s_r.irq)
    else $error("periodic interrupt request missing");

  wdog_reset_a: assert property (
    wdog_to |=> s_r.int_rst && s_r.cpu_rst && s_r.pin_oe)
    else $error("watchdog timeout gave no reset");

  stop_reset_a: assert property (
    stop_rst |=> s_r.int_rst && s_r.cpu_rst)
    else $error("illegal stop gave no reset");

  por_hold_a: assert property (
    s_r.por |-> s_r.cpu_rst)
    else $error("processor released during power-on phase");

  cover_ovf_c: cover property (ovf_evt && !chip_rst);
  cover_per_c: cover property (per_evt && !chip_rst ##1 s_r.irq);
  cover_wdog_c: cover property (wdog_to);
  cover_por_c: cover property ($fell(s_r.por));

endmodule
